//--- hdl/stb_bank.sv
`timescale 1ns/1ns
`include "stb_params.svh"
// Behaviour
// - Charge pump undervoltage sets supply bit 4 until host clears it.
// - Regulator short to ground sets supply bit 3.
// - Regulator overvoltage sets supply bit 1.
// - Regulator below prewarning threshold sets supply bit 0.
// - Bit 2 frozen in restart, gated in init, free after 2 ms short.
// - Sleep with regulator off blocks short, over and undervoltage flags.
// - Stop mode skips internal supply monitor unless peak load or prewarn.
// - Power-on leaves supply MSB set; soft reset leaves it clear.
// - More than 16 consecutive level-2 shutdowns set safe flag, long wait.
// - Level-2 shutdown sets thermal bit 2 and requests fail-safe.
// - Level-1 shutdown sets thermal bit 1, disables affected module only.
// - Thermal prewarning sets thermal bit 0.
// - Thermal flags stay set until host clears them.
// - Restart field encodes cleared, failure, sleep; 11 unused.
// - Failure code on watchdog, shutdown, undervoltage, bad sleep, fail-safe.
// - Checksum failure sets bit 8 except for static enable sequence.
// - Device bit 4 mirrors the development mode pin.
// - Watchdog counter counts failures, saturating at three.
// - Invalid serial command sets device bit 1.
// - Command bit 7 clears supply and thermal registers whole, device bits 8, 7:6, 1, 0 only; data ignored.
// - Only the watchdog counter clears itself.
// - Checksum bits always readable; checksum field of frames ignored.
module stb_bank #(
    parameter int unsigned SHORT_CYCLES = `STB_SHORT_MS * 1000 * `STB_CLK_MHZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic csn,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe_n,
    input wire stb_pkg::stb_det_t det,
    input wire stb_pkg::stb_ctrl_t ctrl,
    output logic fail_safe_req,
    output logic thermal_level1_flag_module_off,
    output logic thermal_level2_flag_long_wait
);
    import stb_pkg::*;

    localparam logic [17:0] SC = 18'(SHORT_CYCLES);
    localparam stb_state_t RST = '{csn_s: 2'h3, csn_p: 1'b1, sup: `STB_SUP_POR,
                                   default: '0};

    logic [31:0] rx_q;
    logic [5:0] cnt_q;
    logic start_q;
    logic [1:0] link_q;
    stb_state_t s_q;
    stb_state_t s_d;
    stb_det_t d;
    logic frame_end;
    logic frame_ok;
    logic [6:0] addr;
    logic clr_sup;
    logic clr_therm;
    logic clr_dev;
    logic uv_upd;
    logic reg_gate;
    logic short_long;
    logic vs_mon;
    logic thermal_level2_flag_edge;
    logic safe_set;
    logic fail_evt;
    logic spi_bad;
    logic any_rst;
    logic [15:0] set_sup;
    logic [15:0] set_therm;
    logic [15:0] rd;

    // Link side: capture on falling edge, LSB first
    always_ff @(negedge sck) begin
        rx_q <= {mosi, rx_q[31:1]};
    end

    // Start marker set by chip select; count itself survives so core can judge it
    always_ff @(negedge sck or posedge csn) begin
        if (csn) begin
            start_q <= 1'b1;
        end else begin
            start_q <= 1'b0;
        end
    end

    always_ff @(negedge sck) begin
        if (start_q) begin
            cnt_q <= 6'h01;
        end else if (cnt_q != 6'h3F) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    // Response launched on rising edge, held stable by core between frames
    always_ff @(posedge sck or posedge csn) begin
        if (csn) begin
            link_q <= 2'h2;
        end else begin
            link_q <= {1'b0, s_q.resp[start_q ? 5'h00 : cnt_q[4:0]]};
        end
    end

    assign miso = link_q[0];
    assign miso_oe_n = link_q[1];

    function automatic logic [15:0] keep(input logic [15:0] v, input logic [15:0] m);
        keep = v & m;
    endfunction : keep

    always_comb begin
        s_d = s_q;
        s_d.csn_s = {s_q.csn_s[0], csn};
        s_d.csn_p = s_q.csn_s[1];
        s_d.det_s1 = det;
        s_d.det_s2 = s_q.det_s1;
        s_d.det_p = s_q.det_s2;
        d = s_q.det_s2;
        any_rst = ctrl.power_on | ctrl.soft_reset;
        // Frame word and count are quiet once chip select is high
        frame_end = s_q.csn_s[1] & ~s_q.csn_p & (cnt_q != 6'h00);
        frame_ok = frame_end & (cnt_q == `STB_FRAME_BITS);
        addr = rx_q[6:0];
        spi_bad = frame_end & ~frame_ok;
        clr_sup = frame_ok & rx_q[`STB_CLR_BIT] & (addr == `STB_ADDR_SUP);
        clr_therm = frame_ok & rx_q[`STB_CLR_BIT] & (addr == `STB_ADDR_THERM);
        clr_dev = frame_ok & rx_q[`STB_CLR_BIT] & (addr == `STB_ADDR_DEV);
        case (addr)
            `STB_ADDR_SUP: rd = keep(s_q.sup, `STB_SUP_MASK);
            `STB_ADDR_THERM: rd = keep(s_q.therm, `STB_THERM_MASK);
            `STB_ADDR_DEV: rd = s_q.dev;
            default: rd = `STB_ZERO;
        endcase
        short_long = (s_q.short_cnt == SC);
        if (!d.reg_low) begin
            s_d.short_cnt = 18'h00000;
        end else if (!short_long) begin
            s_d.short_cnt = s_q.short_cnt + 18'h00001;
        end
        uv_upd = short_long | ((ctrl.mode != STB_RESTART) &
                 ~((ctrl.mode == STB_INIT) & ~ctrl.reset_output_low_released));
        reg_gate = ~((ctrl.mode == STB_SLEEP) & ~d.reg_on);
        vs_mon = (ctrl.mode != STB_STOP) | d.load_peak | s_q.sup[`STB_B_WARN];
        set_sup = `STB_ZERO;
        set_sup[`STB_B_CP] = d.cp_low;
        set_sup[`STB_B_SHORT] = d.reg_short & reg_gate;
        set_sup[`STB_B_HIGH] = d.reg_high & reg_gate;
        set_sup[`STB_B_WARN] = d.reg_prewarn;
        set_sup[`STB_B_LOW] = d.reg_low & uv_upd & reg_gate;
        set_sup[`STB_B_INTERNAL_SUPPLY] = d.internal_supply_low & vs_mon;
        thermal_level2_flag_edge = d.thermal_level2_flag & ~s_q.det_p.thermal_level2_flag;
        safe_set = thermal_level2_flag_edge & (s_q.thermal_level2_flag_cnt >= `STB_THERMAL_LEVEL2_FLAG_LIMIT);
        if ((ctrl.mode == STB_NORMAL) & ~d.thermal_level2_flag) begin
            s_d.thermal_level2_flag_cnt = 5'h00;
        end else if (thermal_level2_flag_edge & (s_q.thermal_level2_flag_cnt != 5'h1F)) begin
            s_d.thermal_level2_flag_cnt = s_q.thermal_level2_flag_cnt + 5'h01;
        end
        set_therm = `STB_ZERO;
        set_therm[`STB_B_TPW] = d.thermal_prewarn_flag;
        set_therm[`STB_B_THERMAL_LEVEL1_FLAG] = d.thermal_level1_flag;
        set_therm[`STB_B_THERMAL_LEVEL2_FLAG] = d.thermal_level2_flag;
        set_therm[`STB_B_SAFE] = safe_set;
        s_d.sup = keep(s_q.sup & ~(clr_sup ? `STB_SUP_MASK : `STB_ZERO) | set_sup,
                       `STB_SUP_MASK);
        s_d.therm = keep(s_q.therm & ~(clr_therm ? `STB_THERM_MASK : `STB_ZERO) |
                         set_therm, `STB_THERM_MASK);
        s_d.dev = keep(s_q.dev & ~(clr_dev ? `STB_DEV_RC_MASK : `STB_ZERO),
                       `STB_DEV_RC_MASK | 16'h000C);
        fail_evt = ctrl.watchdog_fail_counter | thermal_level2_flag_edge | ctrl.sleep_no_wake | ctrl.failsafe_wake |
                   (set_sup[`STB_B_LOW] & ~s_q.det_p.reg_low);
        if (fail_evt) begin
            s_d.dev[7:6] = `STB_CODE_FAIL;
        end else if (ctrl.sleep_wake) begin
            s_d.dev[7:6] = `STB_CODE_SLEEP;
        end
        s_d.dev[`STB_B_FAIL] = s_d.dev[`STB_B_FAIL] | fail_evt;
        s_d.dev[`STB_B_CRCF] = s_d.dev[`STB_B_CRCF] | (ctrl.crc_fail & ~ctrl.crc_static_seq);
        s_d.dev[`STB_B_SPIF] = s_d.dev[`STB_B_SPIF] | spi_bad;
        if (ctrl.watchdog_fail_counter) begin
            if (s_q.dev[3:2] != 2'h3) begin
                s_d.dev[3:2] = s_q.dev[3:2] + 2'h1;
            end
        end else if (ctrl.wd_ok) begin
            s_d.dev[3:2] = 2'h0;
        end
        s_d.dev[`STB_B_CRCST] = ctrl.crc_en;
        s_d.dev[`STB_B_SWDEV] = d.software_development_status;
        if (ctrl.power_on) begin
            s_d.sup = `STB_SUP_POR;
            s_d.therm = `STB_ZERO;
            s_d.dev = keep(s_d.dev, 16'h0210);
            s_d.thermal_level2_flag_cnt = 5'h00;
        end else if (ctrl.soft_reset) begin
            s_d.sup = `STB_ZERO;
            s_d.therm = `STB_ZERO;
            s_d.dev = keep(s_d.dev, 16'h0210);
            s_d.thermal_level2_flag_cnt = 5'h00;
        end else if (ctrl.restart) begin
            s_d.sup = keep(s_q.sup, `STB_SUP_MASK);
            s_d.therm = keep(s_q.therm, `STB_THERM_MASK);
        end
        if (frame_ok) begin
            s_d.resp = {8'h00, rd, rx_q[7:0]};
        end
        s_d.fs_req = thermal_level2_flag_edge;
        s_d.mod_off = d.thermal_level1_flag;
        s_d.long_wait = s_d.therm[`STB_B_SAFE];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign fail_safe_req = s_q.fs_req;
    assign thermal_level1_flag_module_off = s_q.mod_off;
    assign thermal_level2_flag_long_wait = s_q.long_wait;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence clr_sup_s;
        clr_sup && !any_rst && set_sup == `STB_ZERO;
    endsequence

    sequence thermal_level2_flag_17th_s;
        thermal_level2_flag_edge && s_q.thermal_level2_flag_cnt == 5'h10 && !any_rst;
    endsequence

    cp_flag_set_a: assert property (d.cp_low && !any_rst |=> s_q.sup[4])
        else $error("charge pump flag not set");
    short_flag_set_a: assert property (d.reg_short && reg_gate && !any_rst |=> s_q.sup[3])
        else $error("short flag not set");
    uv_restart_hold_a: assert property (ctrl.mode == STB_RESTART && !short_long &&
        !s_q.sup[2] && !ctrl.power_on |=> !s_q.sup[2])
        else $error("undervoltage flag updated in restart");
    sleep_block_a: assert property (ctrl.mode == STB_SLEEP && !d.reg_on &&
        !s_q.sup[1] && !ctrl.power_on |=> !s_q.sup[1])
        else $error("overvoltage flag set with regulator off");
    por_pattern_a: assert property (ctrl.power_on |=> s_q.sup == 16'h8000 &&
        s_q.therm == 16'h0000)
        else $error("power-on pattern wrong");
    safe_state_a: assert property (thermal_level2_flag_17th_s |=> s_q.therm[3] ##0 thermal_level2_flag_long_wait)
        else $error("safe state not reached");
    thermal_level2_flag_failsafe_a: assert property (thermal_level2_flag_edge && !any_rst |=>
        fail_safe_req && s_q.therm[2] ##1 !fail_safe_req)
        else $error("level two shutdown not handled");
    therm_sticky_a: assert property (s_q.therm[0] && !clr_therm && !any_rst |=>
        s_q.therm[0])
        else $error("thermal flag lost");
    wd_saturate_a: assert property (s_q.dev[3:2] == 2'h3 && !ctrl.wd_ok &&
        !any_rst |=> s_q.dev[3:2] == 2'h3)
        else $error("watchdog counter wrapped");
    spi_fail_a: assert property (spi_bad && !any_rst |=> s_q.dev[1])
        else $error("bad frame not flagged");
    clear_word_a: assert property (clr_sup_s |=> s_q.sup == `STB_ZERO &&
        $past(rd) == s_q.resp[23:8])
        else $error("clear not whole word");
    reserved_zero_a: assert property (s_q.sup[14:9] == 6'h00 &&
        s_q.therm[15:4] == 12'h000 && s_q.dev[15:10] == 6'h00 && !s_q.dev[5])
        else $error("reserved bit set");
endmodule : stb_bank

//--- hdl/stb_params.svh
`ifndef STB_PARAMS_SVH
`define STB_PARAMS_SVH
`define STB_ADDR_SUP 7'h40
`define STB_ADDR_THERM 7'h41
`define STB_ADDR_DEV 7'h42
`define STB_SUP_POR 16'h8000
`define STB_ZERO 16'h0000
`define STB_SUP_MASK 16'h811F
`define STB_THERM_MASK 16'h000F
`define STB_DEV_RC_MASK 16'h01C3
`define STB_B_CP 4
`define STB_B_SHORT 3
`define STB_B_LOW 2
`define STB_B_HIGH 1
`define STB_B_WARN 0
`define STB_B_INTERNAL_SUPPLY 8
`define STB_B_SAFE 3
`define STB_B_THERMAL_LEVEL2_FLAG 2
`define STB_B_THERMAL_LEVEL1_FLAG 1
`define STB_B_TPW 0
`define STB_B_CRCST 9
`define STB_B_CRCF 8
`define STB_B_SWDEV 4
`define STB_B_SPIF 1
`define STB_B_FAIL 0
`define STB_CODE_FAIL 2'h1
`define STB_CODE_SLEEP 2'h2
`define STB_FRAME_BITS 6'h20
`define STB_CLR_BIT 7
`define STB_THERMAL_LEVEL2_FLAG_LIMIT 5'h10
`define STB_SHORT_MS 2
`define STB_CLK_MHZ 100
`endif

//--- hdl/stb_pkg.sv
package stb_pkg;
    typedef enum logic [5:0] {
        STB_INIT = 6'h01,
        STB_NORMAL = 6'h02,
        STB_STOP = 6'h04,
        STB_SLEEP = 6'h08,
        STB_RESTART = 6'h10,
        STB_FAILSAFE = 6'h20
    } stb_mode_t;
    typedef struct packed {
        logic cp_low;
        logic reg_short;
        logic reg_high;
        logic reg_low;
        logic reg_prewarn;
        logic internal_supply_low;
        logic load_peak;
        logic reg_on;
        logic thermal_prewarn_flag;
        logic thermal_level1_flag;
        logic thermal_level2_flag;
        logic software_development_status;
    } stb_det_t;
    typedef struct packed {
        stb_mode_t mode;
        logic power_on;
        logic soft_reset;
        logic restart;
        logic reset_output_low_released;
        logic watchdog_fail_counter;
        logic wd_ok;
        logic crc_fail;
        logic crc_static_seq;
        logic crc_en;
        logic sleep_no_wake;
        logic failsafe_wake;
        logic sleep_wake;
    } stb_ctrl_t;
    typedef struct packed {
        logic [1:0] csn_s;
        logic csn_p;
        stb_det_t det_s1;
        stb_det_t det_s2;
        stb_det_t det_p;
        logic [15:0] sup;
        logic [15:0] therm;
        logic [15:0] dev;
        logic [4:0] thermal_level2_flag_cnt;
        logic [17:0] short_cnt;
        logic [31:0] resp;
        logic fs_req;
        logic mod_off;
        logic long_wait;
    } stb_state_t;
endpackage : stb_pkg

//--- testbench/stb_host.sv
`timescale 1ns/1ns
module stb_host (
    output logic sck,
    output logic csn,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sck = 1'b0;
        csn = 1'b1;
        mosi = 1'b0;
    end
    // One frame, LSB first; link clock stands still outside frames
    task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [31:0] rx);
        logic [31:0] tx;
        tx = {8'hA5, 16'hC33C, cmd};
        rx = 32'h00000000;
        #7;
        csn = 1'b0;
        #15;
        for (int k = 0; k < nbits; k++) begin
            sck = 1'b1;
            mosi = tx[k % 32];
            #15;
            sck = 1'b0;
            rx[k % 32] = miso;
            #15;
        end
        csn = 1'b1;
        mosi = ~mosi;
        // Gap well above minimum so the response lands
        #100;
    endtask : xfer
endmodule : stb_host

//--- testbench/stb_bank_tb_top.sv
`timescale 1ns/1ns
`include "stb_params.svh"
module stb_bank_tb_top;
    import stb_pkg::*;
    localparam int P_ON = 11, SOFT = 10, RSTRT = 9, WDF = 7, WDOK = 6, CRCF = 5;
    localparam int NOWAKE = 2, FSWAKE = 1, SLWAKE = 0;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sck, csn, mosi, miso, miso_oe_n;
    logic fail_safe_req, thermal_level1_flag_module_off, thermal_level2_flag_long_wait;
    stb_det_t det;
    stb_ctrl_t ctrl;
    logic [31:0] rx;
    int err_total = 0;
    int checks = 0;
    int fs_cnt = 0;
    int n;
    always #5 clk = ~clk;
    always @(posedge clk) if (fail_safe_req === 1'b1) fs_cnt++;
    stb_host u_stb_host (.sck(sck), .csn(csn), .mosi(mosi), .miso(miso));
    stb_bank #(.SHORT_CYCLES(20)) u_stb_bank (
        .clk(clk), .rst_n(rst_n), .sck(sck), .csn(csn), .mosi(mosi), .miso(miso),
        .miso_oe_n(miso_oe_n), .det(det), .ctrl(ctrl), .fail_safe_req(fail_safe_req),
        .thermal_level1_flag_module_off(thermal_level1_flag_module_off), .thermal_level2_flag_long_wait(thermal_level2_flag_long_wait)
    );
    task automatic conclude;
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // Command frame, then a plain read that returns its answer
    task automatic rd(input logic [6:0] a, input logic clr, input logic [15:0] exp);
        u_stb_host.xfer({clr, a}, 32, rx);
        u_stb_host.xfer({1'b0, a}, 32, rx);
        cmp(rx, {8'h00, exp, clr, a});
        cmp({31'h0, miso_oe_n}, 32'h1);
    endtask : rd
    task automatic dset(input logic [11:0] v);
        @(posedge clk);
        det <= stb_det_t'(v);
        repeat (6) @(posedge clk);
    endtask : dset
    task automatic pulse(input int b);
        logic [17:0] v;
        @(posedge clk);
        v = ctrl;
        v[b] = 1'b1;
        ctrl <= stb_ctrl_t'(v);
        @(posedge clk);
        ctrl <= stb_ctrl_t'(v & ~(18'h1 << b));
        repeat (4) @(posedge clk);
    endtask : pulse
    initial begin
        #500000;
        err_total++;
        conclude();
    end
    initial begin
        ctrl = '0;
        ctrl.mode = STB_NORMAL;
        ctrl.crc_en = 1'b1;
        det = stb_det_t'(12'h011);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`STB_ADDR_SUP, 1'b1, 16'h8000);
        rd(`STB_ADDR_THERM, 1'b0, 16'h0000);
        rd(`STB_ADDR_DEV, 1'b0, 16'h0210);
        rd(7'h43, 1'b1, 16'h0000);
        dset(12'hE91);
        dset(12'h011);
        rd(`STB_ADDR_SUP, 1'b1, 16'h001B);
        rd(`STB_ADDR_SUP, 1'b0, 16'h0000);
        dset(12'h01D);
        cmp({31'h0, thermal_level1_flag_module_off}, 32'h1);
        dset(12'h011);
        rd(`STB_ADDR_THERM, 1'b1, 16'h0003);
        @(posedge clk) ctrl.mode <= STB_FAILSAFE;
        for (n = 1; n <= 17; n++) begin
            dset(12'h013);
            dset(12'h011);
            if (n == 16) rd(`STB_ADDR_THERM, 1'b0, 16'h0004);
        end
        cmp(fs_cnt, 17);
        cmp({31'h0, thermal_level2_flag_long_wait}, 32'h1);
        rd(`STB_ADDR_THERM, 1'b1, 16'h000C);
        rd(`STB_ADDR_DEV, 1'b1, 16'h0251);
        @(posedge clk) ctrl.mode <= STB_NORMAL;
        for (n = 1; n <= 4; n++) begin
            pulse(WDF);
            rd(`STB_ADDR_DEV, 1'b1, 16'h0251 | 16'((n > 3 ? 3 : n) << 2));
        end
        pulse(WDOK);
        rd(`STB_ADDR_DEV, 1'b0, 16'h0210);
        @(posedge clk) ctrl.crc_static_seq <= 1'b1;
        pulse(CRCF);
        @(posedge clk) ctrl.crc_static_seq <= 1'b0;
        rd(`STB_ADDR_DEV, 1'b0, 16'h0210);
        pulse(CRCF);
        @(posedge clk) ctrl.crc_en <= 1'b0;
        rd(`STB_ADDR_DEV, 1'b1, 16'h0110);
        @(posedge clk) ctrl.crc_en <= 1'b1;
        u_stb_host.xfer(8'h42, 31, rx);
        rd(`STB_ADDR_DEV, 1'b1, 16'h0212);
        u_stb_host.xfer(8'hC2, 33, rx);
        rd(`STB_ADDR_DEV, 1'b1, 16'h0212);
        pulse(SLWAKE);
        rd(`STB_ADDR_DEV, 1'b1, 16'h0290);
        pulse(NOWAKE);
        rd(`STB_ADDR_DEV, 1'b1, 16'h0251);
        pulse(FSWAKE);
        rd(`STB_ADDR_DEV, 1'b1, 16'h0251);
        @(posedge clk) ctrl.mode <= STB_SLEEP;
        dset(12'h701);
        dset(12'h011);
        rd(`STB_ADDR_SUP, 1'b0, 16'h0000);
        @(posedge clk) ctrl.mode <= STB_STOP;
        dset(12'h051);
        dset(12'h011);
        rd(`STB_ADDR_SUP, 1'b0, 16'h0000);
        dset(12'h071);
        dset(12'h011);
        rd(`STB_ADDR_SUP, 1'b1, 16'h0100);
        dset(12'h0D1);
        dset(12'h011);
        rd(`STB_ADDR_SUP, 1'b1, 16'h0101);
        @(posedge clk) ctrl.mode <= STB_RESTART;
        dset(12'h111);
        dset(12'h011);
        rd(`STB_ADDR_SUP, 1'b0, 16'h0000);
        dset(12'h111);
        repeat (30) @(posedge clk);
        dset(12'h011);
        rd(`STB_ADDR_SUP, 1'b1, 16'h0004);
        u_stb_host.xfer(8'hC2, 32, rx);
        @(posedge clk) ctrl.mode <= STB_INIT;
        dset(12'h111);
        dset(12'h011);
        rd(`STB_ADDR_SUP, 1'b0, 16'h0000);
        @(posedge clk) ctrl.reset_output_low_released <= 1'b1;
        dset(12'h111);
        dset(12'h011);
        rd(`STB_ADDR_SUP, 1'b1, 16'h0004);
        rd(`STB_ADDR_DEV, 1'b1, 16'h0251);
        @(posedge clk) ctrl.mode <= STB_NORMAL;
        dset(12'h019);
        dset(12'h011);
        pulse(RSTRT);
        rd(`STB_ADDR_THERM, 1'b0, 16'h0001);
        pulse(SOFT);
        rd(`STB_ADDR_SUP, 1'b0, 16'h0000);
        rd(`STB_ADDR_THERM, 1'b0, 16'h0000);
        pulse(P_ON);
        rd(`STB_ADDR_SUP, 1'b0, 16'h8000);
        conclude();
    end
endmodule : stb_bank_tb_top
